// ===== rtl/shpfp_pkg.sv
// constants, field layouts and carrier types for the forwarding policy block
// What this block does
// - forwarding state: transmit, receive and learn
// - three-bit tree index picks per-port state
// - append ingress-port tag toward host port
// - host tag names egress port and queue
// - strip tail tag before frame egresses
// - tag sits just before four-byte check
// - trap IPv4 IGMP frames to host only
// - known multicast goes to member ports only
// - trap MLD frames to host only
// - receive-mirrored frames copied to sniffer port
// - transmit-mirrored frames copied to sniffer port
// - receive-and-transmit pair mirrored when both match
// - many sniffed ports, any sniffer port
// - strict priority, queue three highest
// - weighted round robin gives proportional share
// - rate above link speed means unlimited
// - counted size adds optional gap, preamble
// - ingress limit counts classes, drops excess
// - egress leaky bucket stretches frame gap
// - exhausted buffer drops or asserts pause
// - shaper on at most two queues
package shpfp_pkg;
  localparam int NPORT = 3;
  localparam int NQ    = 4;
  localparam int PS_W  = 3;
  localparam int RATE_W = 10;
  localparam int BKT_W = 24;
  localparam int LEN_W = 11;
  // register byte offsets
  localparam logic [7:0] A_PSTATE0 = 8'h00;
  localparam logic [7:0] A_GCTRL   = 8'h0C;
  localparam logic [7:0] A_SCHED   = 8'h10;
  localparam logic [7:0] A_ERATE0  = 8'h14;
  localparam logic [7:0] A_IRATE0  = 8'h24;
  localparam logic [7:0] A_STATUS  = 8'h30;
  localparam logic [7:0] A_DROPS   = 8'h34;
  localparam logic [7:0] A_STEP    = 8'h04;
  // per-tree port state bits
  localparam int PS_TX = 0;
  localparam int PS_RX = 1;
  localparam int PS_LD = 2;
  localparam logic [23:0] PS_RST = 24'h6DB6DB;
  // global control fields
  localparam int GC_TTAG = 0;
  localparam int GC_RXS  = 8;
  localparam int GC_TXS  = 12;
  localparam int GC_SNF  = 16;
  localparam int GC_BAD  = 20;
  localparam int GC_RXTX = 21;
  localparam int GC_FC   = 24;
  localparam int GC_MQ   = 25;
  localparam int GC_IFG  = 27;
  localparam int GC_PRE  = 28;
  localparam logic [31:0] GC_WMASK = 32'h1B37_7707;
  // scheduler fields
  localparam int SC_WRR  = 0;
  localparam int SC_FOURQ = 1;
  localparam int SC_CBS  = 4;
  localparam logic [31:0] SC_WMASK = 32'h0000_00F3;
  localparam logic [NQ-1:0] Q_ALL  = 4'hF;
  localparam logic [NQ-1:0] Q_TWO  = 4'h3;
  localparam logic [NQ-1:0] CBS_4Q = 4'hC;
  localparam logic [NQ-1:0] CBS_2Q = 4'h2;
  localparam logic [1:0] Q_TOP = 2'h3;
  localparam logic [3:0] WRR_W [NQ] = '{4'h1, 4'h2, 4'h4, 4'h8};
  // ingress rate class field and codes
  localparam int IR_CLS = 12;
  localparam logic [1:0] CLS_ALL = 2'h0;
  localparam logic [1:0] CLS_MC  = 2'h1;
  localparam logic [1:0] CLS_BC  = 2'h2;
  // status fields
  localparam int ST_FC   = 0;
  localparam int ST_HOST = 4;
  localparam int ST_CERR = 5;
  // link speed codes and limits in Mbps
  localparam logic [1:0] SPD_10  = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [RATE_W-1:0] LIM_10   = 10'h00A;
  localparam logic [RATE_W-1:0] LIM_100  = 10'h064;
  localparam logic [RATE_W-1:0] LIM_1000 = 10'h3E8;
  // byte counts and bucket cost per byte at the core clock rate
  localparam int CLK_MHZ = 100;
  localparam int BITS_PER_BYTE = 8;
  localparam logic [BKT_W-1:0] COST_B = BKT_W'(BITS_PER_BYTE * CLK_MHZ);
  localparam logic [11:0] IFG_BYTES = 12'h00C;
  localparam logic [11:0] PRE_BYTES = 12'h008;
  localparam logic [LEN_W-1:0] FCS_BYTES = 11'h004;
  // frame header recognition
  localparam logic [3:0] IP_VER_V4 = 4'h4;
  localparam logic [7:0] IP_PROTO_IGMP = 8'h02;
  // tail tag layout
  localparam int TAG_MASK = 0;
  localparam int TAG_Q = 8;
  localparam logic [NPORT-1:0] P_ONE = 3'h1;

  typedef struct packed {
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [7:0]       paddr;
    logic [31:0]      pwdata;
    logic [3:0]       pstrb;
  } shpfp_apb_req_t;

  typedef struct packed {
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } shpfp_apb_rsp_t;

  // one frame descriptor from lookup and parser
  typedef struct packed {
    logic             vld;
    logic [1:0]       in_port;
    logic [NPORT-1:0] lk_mask;
    logic             lk_hit;
    logic             mcast;
    logic             bcast;
    logic             ip;
    logic [3:0]       ip_ver;
    logic [7:0]       ip_proto;
    logic             mld;
    logic             err;
    logic [2:0]       tree;
    logic [15:0]      tag;
    logic [LEN_W-1:0] len;
  } shpfp_frm_t;

  // forwarding decision for that frame
  typedef struct packed {
    logic             vld;
    logic             drop;
    logic [NPORT-1:0] mask;
    logic [1:0]       queue;
    logic             add_tag;
    logic             strip;
    logic [15:0]      tag;
    logic [LEN_W-1:0] tag_off;
    logic             learn;
  } shpfp_dec_t;
endpackage : shpfp_pkg

// ===== rtl/shpfp_top.sv
// frame forwarding policy, egress scheduler, rate limiters and apb registers
`timescale 1ns/1ns
module shpfp_top #(
  parameter int IBURST   = 1228800,
  parameter int EGR_PORT = 0
) (
  // clock and reset
  input  wire logic                                  i_ref_clk,
  input  wire logic                                  i_rstn,
  // register bus
  input  wire shpfp_pkg::shpfp_apb_req_t             i_apb,
  output shpfp_pkg::shpfp_apb_rsp_t                  o_apb,
  // frame decision
  input  wire shpfp_pkg::shpfp_frm_t                 i_frm,
  output shpfp_pkg::shpfp_dec_t                      o_dec,
  // port status
  input  wire logic [shpfp_pkg::NPORT-1:0][1:0]      i_link_speed,
  input  wire logic [shpfp_pkg::NPORT-1:0]           i_buf_full,
  output logic [shpfp_pkg::NPORT-1:0]                o_flow_ctrl,
  // egress queues
  input  wire logic [shpfp_pkg::NQ-1:0]              i_q_ready,
  input  wire logic [shpfp_pkg::NQ-1:0][shpfp_pkg::LEN_W-1:0] i_q_len,
  input  wire logic                                  i_tx_idle,
  output logic                                       o_grant_vld,
  output logic [1:0]                                 o_grant_q,
  output logic [shpfp_pkg::NQ-1:0]                   o_cbs_en
);
  import shpfp_pkg::*;

  typedef struct packed {
    logic [NPORT-1:0][23:0]       pstate;
    logic [31:0]                  gctrl;
    logic [31:0]                  sched;
    logic [NQ-1:0][RATE_W-1:0]    erate;
    logic [NPORT-1:0][13:0]       irate;
    logic [NPORT-1:0][BKT_W-1:0]  ibkt;
    logic [NQ-1:0][BKT_W-1:0]     ebkt;
    logic [NQ-1:0][3:0]           wcnt;
    logic [15:0]                  drops;
    shpfp_dec_t                   dec;
    logic                         gvld;
    logic [1:0]                   gq;
    logic [NPORT-1:0]             fc;
    logic [NQ-1:0]                cbs;
    logic [31:0]                  prdata;
    logic                         pslverr;
  } shpfp_state_t;

  shpfp_state_t st_ff;
  shpfp_state_t nxt_st;

  // byte-lane merge for apb writes
  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] w,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = w[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // a rate of zero or one above the link speed leaves traffic unlimited
  function automatic logic limited(input logic [RATE_W-1:0] r, input logic [1:0] s);
    logic [RATE_W-1:0] lim;
    lim = (s == SPD_10) ? LIM_10 : (s == SPD_100) ? LIM_100 : LIM_1000;
    return (r != '0) && (r <= lim);
  endfunction : limited

  // bucket cost of one frame, size option bits included
  function automatic logic [BKT_W-1:0] cost(input logic [LEN_W-1:0] len,
                                            input logic ifg, input logic pre);
    logic [11:0] sz;
    sz = 12'(len) + (ifg ? IFG_BYTES : '0) + (pre ? PRE_BYTES : '0);
    return BKT_W'(BKT_W'(sz) * COST_B);
  endfunction : cost

  function automatic logic [BKT_W-1:0] drain(input logic [BKT_W-1:0] l,
                                             input logic [RATE_W-1:0] r);
    return (l > BKT_W'(r)) ? l - BKT_W'(r) : '0;
  endfunction : drain

  // decoded configuration
  logic [NPORT-1:0]          ttag;
  logic [NPORT-1:0]          rxs;
  logic [NPORT-1:0]          txs;
  logic [NPORT-1:0]          snf;
  logic [NPORT-1:0]          host;
  logic                      host_ok;
  logic [NPORT-1:0]          in_oh;
  logic                      from_host;
  logic                      igmp;
  logic [NPORT-1:0][PS_W-1:0] ps_cur;
  logic [NPORT-1:0]          tx_ok;
  logic [1:0]                icls;
  logic                      cls_hit;
  logic                      irl_drop;
  logic [NQ-1:0]             elim;
  logic [NQ-1:0]             elig;
  logic [NQ-1:0]             cbs_ok;
  logic                      cbs_err;

  assign ttag = st_ff.gctrl[GC_TTAG +: NPORT];
  assign rxs  = st_ff.gctrl[GC_RXS +: NPORT];
  assign txs  = st_ff.gctrl[GC_TXS +: NPORT];
  assign snf  = st_ff.gctrl[GC_SNF +: NPORT];
  // a second tail-tag port would confuse the host, so treat it as none
  assign host_ok = (ttag != '0) && ((ttag & (ttag - P_ONE)) == '0);
  assign host    = host_ok ? ttag : '0;
  assign in_oh   = P_ONE << i_frm.in_port;
  assign from_host = |(in_oh & host);
  assign igmp = i_frm.ip && (i_frm.ip_ver == IP_VER_V4) && (i_frm.ip_proto == IP_PROTO_IGMP);

  // per-port state of the tree the frame belongs to
  for (genvar p = 0; p < NPORT; p++) begin : g_ps
    assign ps_cur[p] = st_ff.pstate[p][i_frm.tree*PS_W +: PS_W];
    assign tx_ok[p]  = ps_cur[p][PS_TX];
  end

  // ingress class selection
  assign icls = st_ff.irate[i_frm.in_port][IR_CLS +: 2];
  always_comb begin : cls_sel
    unique case (icls)
      CLS_ALL: cls_hit = 1'b1;
      CLS_MC:  cls_hit = i_frm.mcast;
      CLS_BC:  cls_hit = i_frm.bcast;
      default: cls_hit = !i_frm.lk_hit && !i_frm.mcast && !i_frm.bcast;
    endcase
  end
  assign irl_drop = i_frm.vld && cls_hit
                 && limited(st_ff.irate[i_frm.in_port][RATE_W-1:0],
                            i_link_speed[i_frm.in_port])
                 && (st_ff.ibkt[i_frm.in_port] > BKT_W'(IBURST));

  // queues eligible for egress
  for (genvar q = 0; q < NQ; q++) begin : g_q
    assign elim[q] = limited(st_ff.erate[q], i_link_speed[EGR_PORT]);
    assign elig[q] = i_q_ready[q] && (st_ff.sched[SC_FOURQ] ? Q_ALL[q] : Q_TWO[q])
                  && (!elim[q] || st_ff.ebkt[q] == '0);
  end

  // shaper may only sit on the top queue or top two queues
  assign cbs_ok  = st_ff.sched[SC_FOURQ] ? CBS_4Q : CBS_2Q;
  assign cbs_err = |(st_ff.sched[SC_CBS +: NQ] & ~cbs_ok);

  // next-state for the whole block
  always_comb begin : comb_next
    logic [NPORT-1:0] dm;
    logic [NPORT-1:0] pre_full;
    logic             drop;
    logic             rxm;
    logic             txm;
    logic             mir;
    logic [1:0]       qsel;
    logic             any;
    logic             wany;
    logic [7:0]       a;
    logic [31:0]      rd;
    logic             hit;
    dm = '0;
    pre_full = '0;
    drop = 1'b0;
    rxm = 1'b0;
    txm = 1'b0;
    mir = 1'b0;
    qsel = '0;
    any = 1'b0;
    wany = 1'b0;
    a = i_apb.paddr;
    rd = '0;
    hit = 1'b0;
    nxt_st = st_ff;

    // destination choice
    nxt_st.dec.queue = '0;
    if (from_host) begin
      dm = i_frm.tag[TAG_MASK +: NPORT] & ~host;
      if (st_ff.gctrl[GC_MQ]) begin
        nxt_st.dec.queue = i_frm.tag[TAG_Q +: 2];
      end
    end else if (igmp || i_frm.mld) begin
      dm = host & ~in_oh;
    end else if (i_frm.lk_hit) begin
      dm = i_frm.lk_mask & ~in_oh;
    end else begin
      dm = ~in_oh;
    end
    // spanning tree gating, host traffic still passes
    if (!from_host) begin
      if (!ps_cur[i_frm.in_port][PS_RX]) begin
        dm = dm & host;
      end
      dm = dm & (tx_ok | host);
    end
    drop = irl_drop || i_frm.err;
    if (drop) begin
      dm = '0;
    end
    // mirroring
    rxm = |(in_oh & rxs);
    txm = |(dm & txs);
    mir = st_ff.gctrl[GC_RXTX] ? (rxm && txm) : (rxm || txm);
    if (i_frm.err && !irl_drop) begin
      mir = rxm && st_ff.gctrl[GC_BAD] && !st_ff.gctrl[GC_RXTX];
    end else if (irl_drop) begin
      mir = 1'b0;
    end
    if (mir) begin
      dm = dm | (snf & ~in_oh);
    end
    // full buffers: pause the senders or shed the frame
    pre_full = dm;
    if (!st_ff.gctrl[GC_FC]) begin
      dm = dm & ~i_buf_full;
    end
    nxt_st.fc = st_ff.gctrl[GC_FC] ? i_buf_full : '0;
    if (i_frm.vld && (drop || dm != pre_full)) begin
      nxt_st.drops = st_ff.drops + 16'h0001;
    end

    nxt_st.dec.vld  = i_frm.vld;
    if (i_frm.vld) begin
      nxt_st.dec.drop    = drop;
      nxt_st.dec.mask    = dm;
      nxt_st.dec.add_tag = |(dm & host);
      nxt_st.dec.tag     = '0;
      nxt_st.dec.tag[TAG_MASK +: NPORT] = in_oh;
      nxt_st.dec.strip   = from_host;
      nxt_st.dec.tag_off = i_frm.len - FCS_BYTES;
      nxt_st.dec.learn   = !ps_cur[i_frm.in_port][PS_LD] && !i_frm.err && !from_host;
    end

    // ingress buckets leak at the programmed rate
    for (int p = 0; p < NPORT; p++) begin
      if (limited(st_ff.irate[p][RATE_W-1:0], i_link_speed[p])) begin
        nxt_st.ibkt[p] = drain(st_ff.ibkt[p], st_ff.irate[p][RATE_W-1:0]);
        if (i_frm.vld && !irl_drop && cls_hit && in_oh[p]) begin
          nxt_st.ibkt[p] = nxt_st.ibkt[p]
                         + cost(i_frm.len, st_ff.gctrl[GC_IFG], st_ff.gctrl[GC_PRE]);
        end
      end else begin
        nxt_st.ibkt[p] = '0;
      end
    end

    // egress pick: strict takes the highest, wrr skips spent queues
    for (int q = 0; q < NQ; q++) begin
      if (elig[q]) begin
        any = 1'b1;
        if (st_ff.wcnt[q] < WRR_W[q]) begin
          wany = 1'b1;
        end
      end
    end
    for (int q = 0; q < NQ; q++) begin
      if (elig[q] && (!st_ff.sched[SC_WRR] || !wany || st_ff.wcnt[q] < WRR_W[q])) begin
        qsel = 2'(q);
      end
    end
    nxt_st.gvld = i_tx_idle && !st_ff.gvld && any;
    if (nxt_st.gvld) begin
      nxt_st.gq = qsel;
      if (st_ff.sched[SC_WRR]) begin
        if (!wany) begin
          nxt_st.wcnt = '0;
        end
        nxt_st.wcnt[qsel] = (wany ? st_ff.wcnt[qsel] : 4'h0) + 4'h1;
      end
    end
    // egress buckets: leak, then charge the frame, which stretches the gap
    for (int q = 0; q < NQ; q++) begin
      if (elim[q]) begin
        nxt_st.ebkt[q] = drain(st_ff.ebkt[q], st_ff.erate[q]);
        if (nxt_st.gvld && qsel == 2'(q)) begin
          nxt_st.ebkt[q] = nxt_st.ebkt[q]
                         + cost(i_q_len[q], st_ff.gctrl[GC_IFG], st_ff.gctrl[GC_PRE]);
        end
      end else begin
        nxt_st.ebkt[q] = '0;
      end
    end
    nxt_st.cbs = st_ff.sched[SC_CBS +: NQ] & cbs_ok;

    // apb read decode in the setup cycle so data is ready at access
    if (a == A_GCTRL) begin
      rd = st_ff.gctrl;
      hit = 1'b1;
    end
    if (a == A_SCHED) begin
      rd = st_ff.sched;
      hit = 1'b1;
    end
    if (a == A_STATUS) begin
      rd[ST_FC +: NPORT] = st_ff.fc;
      rd[ST_HOST] = host_ok;
      rd[ST_CERR] = cbs_err;
      hit = 1'b1;
    end
    if (a == A_DROPS) begin
      rd = 32'(st_ff.drops);
      hit = 1'b1;
    end
    for (int p = 0; p < NPORT; p++) begin
      if (a == A_PSTATE0 + 8'(p) * A_STEP) begin
        rd = 32'(st_ff.pstate[p]);
        hit = 1'b1;
        if (i_apb.psel && i_apb.penable && i_apb.pwrite) begin
          nxt_st.pstate[p] = 24'(wmerge(rd, i_apb.pwdata, i_apb.pstrb));
        end
      end
      if (a == A_IRATE0 + 8'(p) * A_STEP) begin
        rd = 32'(st_ff.irate[p]);
        hit = 1'b1;
        if (i_apb.psel && i_apb.penable && i_apb.pwrite) begin
          nxt_st.irate[p] = 14'(wmerge(rd, i_apb.pwdata, i_apb.pstrb));
        end
      end
    end
    for (int q = 0; q < NQ; q++) begin
      if (a == A_ERATE0 + 8'(q) * A_STEP) begin
        rd = 32'(st_ff.erate[q]);
        hit = 1'b1;
        if (i_apb.psel && i_apb.penable && i_apb.pwrite) begin
          nxt_st.erate[q] = RATE_W'(wmerge(rd, i_apb.pwdata, i_apb.pstrb));
        end
      end
    end
    if (i_apb.psel && i_apb.penable && i_apb.pwrite) begin
      if (a == A_GCTRL) begin
        nxt_st.gctrl = wmerge(st_ff.gctrl, i_apb.pwdata, i_apb.pstrb) & GC_WMASK;
      end
      if (a == A_SCHED) begin
        nxt_st.sched = wmerge(st_ff.sched, i_apb.pwdata, i_apb.pstrb) & SC_WMASK;
      end
    end
    if (i_apb.psel && !i_apb.penable) begin
      nxt_st.prdata  = i_apb.pwrite ? '0 : rd;
      nxt_st.pslverr = !hit;
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_ff        <= '0;
      st_ff.pstate <= {NPORT{PS_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // zero-wait slave: access phase always completes in one cycle
  assign o_apb.pready  = 1'b1;
  assign o_apb.prdata  = st_ff.prdata;
  assign o_apb.pslverr = st_ff.pslverr;
  assign o_dec       = st_ff.dec;
  assign o_grant_vld = st_ff.gvld;
  assign o_grant_q   = st_ff.gq;
  assign o_flow_ctrl = st_ff.fc;
  assign o_cbs_en    = st_ff.cbs;

  // checks
  a_igmp_host_only: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_frm.vld && igmp && !from_host) |=> ((o_dec.mask & ~($past(host) | $past(snf))) == '0))
    else $error("igmp frame left toward a non-host port");
  a_host_strip: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_frm.vld && from_host) |=> (o_dec.vld && o_dec.strip && !o_dec.add_tag))
    else $error("host frame not stripped");
  a_tag_to_host: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_dec.vld |-> (o_dec.add_tag == (|(o_dec.mask & $past(host)))))
    else $error("tail tag append does not match host port");
  a_tag_offset: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_dec.vld && (o_dec.add_tag || o_dec.strip)) |-> (o_dec.tag_off == $past(i_frm.len) - FCS_BYTES))
    else $error("tail tag offset not before check sequence");
  a_strict_top: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (o_grant_vld && !$past(st_ff.sched[SC_WRR]) && $past(elig[3])) |-> (o_grant_q == Q_TOP))
    else $error("strict priority did not pick the top queue");
  a_wrr_share: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (st_ff.wcnt[0] <= WRR_W[0]) && (st_ff.wcnt[1] <= WRR_W[1]) && (st_ff.wcnt[2] <= WRR_W[2])
    && (st_ff.wcnt[3] <= WRR_W[3]))
    else $error("round robin share exceeded");
  a_stp_block: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_frm.vld && !from_host && !ps_cur[i_frm.in_port][PS_RX])
    |=> ((o_dec.mask & ~($past(host) | $past(snf))) == '0))
    else $error("non-forwarding port passed user traffic");
  a_rx_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (i_frm.vld && rxs[i_frm.in_port] && !st_ff.gctrl[GC_RXTX] && !i_frm.err && !irl_drop
     && i_buf_full == '0) |=> ((o_dec.mask & $past(snf & ~in_oh)) == $past(snf & ~in_oh)))
    else $error("receive mirror copy missing");
  a_unlim_rate: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (st_ff.erate[3] > LIM_100 && i_link_speed[EGR_PORT] == SPD_100) |=> (st_ff.ebkt[3] == '0))
    else $error("rate above link speed was limited");
  a_irl_drop: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    irl_drop |=> (o_dec.drop && o_dec.mask == '0))
    else $error("over-rate frame not dropped");
  a_cbs_limit: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ($countones(o_cbs_en) <= 2) && ((o_cbs_en & ~(CBS_4Q | CBS_2Q)) == '0))
    else $error("shaper enabled on a disallowed queue");
endmodule : shpfp_top

// ===== sim/shpfp_host_model.sv
// host processor model: builds tail-tagged frame descriptors toward the switch
`timescale 1ns/1ns
module shpfp_host_model (
  // request from the bench
  input  wire logic [2:0]                  i_dest,
  input  wire logic [1:0]                  i_q,
  // descriptor as the host port presents it
  output shpfp_pkg::shpfp_frm_t            o_frm
);
  import shpfp_pkg::*;
  // host appends two tag bytes before the check sequence
  always_comb begin
    o_frm         = '0;
    o_frm.in_port = 2'h0;
    o_frm.tag     = {6'h00, i_q, 5'h00, i_dest};
    o_frm.len     = 11'h042;
  end
endmodule : shpfp_host_model

// ===== sim/shpfp_top_tb.sv
// self-checking bench for the forwarding policy block
`timescale 1ns/1ns
module shpfp_top_tb;
  import shpfp_pkg::*;
  logic i_ref_clk, i_rstn;
  shpfp_apb_req_t apb;
  shpfp_apb_rsp_t o_apb;
  shpfp_frm_t frm, hfrm;
  shpfp_dec_t o_dec;
  logic [NPORT-1:0] buf_full, o_flow_ctrl;
  logic [NQ-1:0] q_rdy, o_cbs_en;
  logic tx_idle, o_grant_vld;
  logic [1:0] o_grant_q;
  logic [31:0] rd;
  logic serr;
  logic [NPORT-1:0][1:0] spd;
  int errors, checks_done;
  shpfp_top #(.IBURST(8000)) uut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_apb(apb),
    .o_apb(o_apb), .i_frm(frm), .o_dec(o_dec), .i_link_speed(spd), .i_buf_full(buf_full),
    .o_flow_ctrl(o_flow_ctrl), .i_q_ready(q_rdy), .i_q_len({4{11'h040}}),
    .i_tx_idle(tx_idle), .o_grant_vld(o_grant_vld), .o_grant_q(o_grant_q),
    .o_cbs_en(o_cbs_en));
  shpfp_host_model host (.i_dest(3'h4), .i_q(2'h1), .o_frm(hfrm));
  initial begin
    i_ref_clk = 0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // setup then access, held until pready seen high
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d, pstrb: 4'hF};
    @(posedge i_ref_clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (o_apb.pready !== 1'b1);
    rd = o_apb.prdata;
    serr = o_apb.pslverr;
    apb <= '0;
  endtask : bus
  // one descriptor in, decision checked one cycle later
  task fr(input shpfp_frm_t f, input logic [2:0] m);
    @(posedge i_ref_clk);
    frm <= f;
    @(posedge i_ref_clk);
    frm.vld <= 1'b0;
    #1;
    chk(o_dec.vld, 1);
    chk(o_dec.mask, m);
  endtask : fr
  function automatic shpfp_frm_t mk(input logic [1:0] p, input logic [2:0] m);
    mk = '0;
    mk.vld = 1'b1;
    mk.in_port = p;
    mk.lk_mask = m;
    mk.lk_hit = 1'b1;
    mk.len = 11'h040;
    return mk;
  endfunction : mk
  task t_regs;
    bus(0, A_PSTATE0, 0);
    chk(rd, 32'h006DB6DB);
    bus(0, 8'h40, 0);
    chk(serr, 1);
    bus(1, 8'h04, 32'h006E36DB);
    bus(0, 8'h04, 0);
    chk(rd, 32'h006E36DB);
    fr(mk(1, 3'h4), 3'h4);
  endtask : t_regs
  task t_tree;
    shpfp_frm_t f;
    f = mk(1, 3'h4);
    f.tree = 3'h5;
    fr(f, 3'h0);
    f.tree = 3'h4;
    fr(f, 3'h4);
    chk(o_dec.learn, 1);
  endtask : t_tree
  task t_tag;
    shpfp_frm_t f;
    bus(1, A_GCTRL, 32'h0200_0001);
    fr(mk(2, 3'h1), 3'h1);
    chk(o_dec.add_tag, 1);
    chk(o_dec.tag[2:0], 3'h4);
    chk(o_dec.tag_off, 11'h03C);
    f = hfrm;
    f.vld = 1'b1;
    fr(f, 3'h4);
    chk(o_dec.strip, 1);
    chk(o_dec.queue, 2'h1);
  endtask : t_tag
  task t_trap;
    shpfp_frm_t f;
    f = mk(1, 3'h6);
    f.ip = 1'b1;
    f.ip_ver = 4'h4;
    f.ip_proto = 8'h02;
    fr(f, 3'h1);
    f = mk(2, 3'h3);
    f.mld = 1'b1;
    fr(f, 3'h1);
    f = mk(2, 3'h2);
    f.mcast = 1'b1;
    fr(f, 3'h2);
  endtask : t_trap
  task t_mirror;
    bus(1, A_GCTRL, 32'h0001_0201);
    fr(mk(1, 3'h4), 3'h5);
    bus(1, A_GCTRL, 32'h0001_4001);
    fr(mk(1, 3'h4), 3'h5);
    bus(1, A_GCTRL, 32'h0004_6000);
    fr(mk(0, 3'h2), 3'h6);
    bus(1, A_GCTRL, 32'h0021_4201);
    fr(mk(1, 3'h4), 3'h5);
  endtask : t_mirror
  task t_sched(input logic [3:0] r, input logic [1:0] q);
    @(posedge i_ref_clk);
    q_rdy <= r;
    tx_idle <= 1'b1;
    do begin
      @(posedge i_ref_clk);
    end while (o_grant_vld !== 1'b1);
    chk(o_grant_q, q);
    tx_idle <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
  endtask : t_sched
  task t_flow;
    bus(1, A_GCTRL, 32'h0100_0001);
    @(posedge i_ref_clk);
    buf_full <= 3'h2;
    repeat (2) @(posedge i_ref_clk);
    buf_full <= 3'h0;
    #1;
    chk(o_flow_ctrl, 3'h2);
    // shaper asked on every queue, only the top two may keep it
    bus(1, A_SCHED, 32'h0000_00F3);
    @(posedge i_ref_clk);
    #1;
    chk(o_cbs_en, 4'hC);
    bus(0, A_STATUS, 0);
    chk(rd, 32'h0000_0030);
    // drop mode: a full egress port loses its copy
    bus(1, A_GCTRL, 32'h0000_0000);
    buf_full <= 3'h4;
    fr(mk(1, 3'h4), 3'h0);
    @(posedge i_ref_clk);
    buf_full <= 3'h0;
  endtask : t_flow
  // ingress limit on port 1, class filter, then over-speed rate on a 10M link
  task t_rate;
    bus(1, A_IRATE0 + 8'h04, 32'h0000_000A);
    fr(mk(1, 3'h4), 3'h4);
    fr(mk(1, 3'h4), 3'h0);
    chk(o_dec.drop, 1);
    bus(1, A_IRATE0 + 8'h04, 32'h0000_100A);
    fr(mk(1, 3'h4), 3'h4);
    bus(1, A_IRATE0 + 8'h04, 32'h0000_000B);
    spd <= {2'h1, 2'h0, 2'h1};
    fr(mk(1, 3'h4), 3'h4);
    bus(0, A_DROPS, 0);
    chk(rd, 32'h0000_0002);
  endtask : t_rate
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
  initial begin
    i_rstn = 0;
    apb = '0;
    frm = '0;
    buf_full = '0;
    q_rdy = '0;
    tx_idle = 0;
    spd = {3{2'h1}};
    repeat (6) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    t_regs();
    t_tree();
    t_tag();
    t_trap();
    t_mirror();
    bus(1, A_SCHED, 32'h0000_0002);
    t_sched(4'hC, 2'h3);
    t_sched(4'h6, 2'h2);
    // weighted mode: the top queue spends its eight turns, then queue 2 gets one
    bus(1, A_SCHED, 32'h0000_0003);
    repeat (8) t_sched(4'hC, 2'h3);
    t_sched(4'hC, 2'h2);
    // egress limit on queue 3 holds it back, then a rate above link speed clears its bucket
    bus(1, A_SCHED, 32'h0000_0002);
    bus(1, A_ERATE0 + 8'h0C, 32'h0000_0064);
    t_sched(4'hC, 2'h3);
    t_sched(4'hC, 2'h2);
    bus(1, A_ERATE0 + 8'h0C, 32'h0000_0065);
    t_sched(4'hC, 2'h3);
    t_flow();
    t_rate();
    give_verdict();
  end
endmodule : shpfp_top_tb
